/* File: shared/tcsef_pkg.sv */
// constants, field layouts and enumerations of the transmitter c/u source and event flag block
// assumes one clock, a byte-wide register port and host reads that clear the event flags
//
// Notes on behaviour
// - two-bit field picks the buffer loading source
// - validity bit from stored value or receiver
// - transfer-done flag sets when enabled and unmasked
// - transfer-done flag pulls interrupt, sets transmitter summary
// - slip flag triggers on slip or block start
// - slip flag pulls interrupt, sets transmitter summary
// - rate-ready flag sets, pulls interrupt, converter summary
// - ratio flag sets, pulls interrupt, converter summary
// - mask bits enable events, zero masks them
// - per-event trigger modes: rise, fall, level, reserved
// - status register is read-only, writes ignored
// - disable bit blocks transfers; updates need nonzero source

package tcsef_pkg;

	// ===========================================================
	// register port and offsets
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;
	localparam logic [7:0] OFF_SUMMARY = 8'h02;
	localparam logic [7:0] OFF_TX_CTL1 = 8'h07;
	localparam logic [7:0] OFF_TX_CTL2 = 8'h08;
	localparam logic [7:0] OFF_CU_SRC = 8'h09;
	localparam logic [7:0] OFF_EVT_STAT = 8'h0A;
	localparam logic [7:0] OFF_EVT_MASK = 8'h0B;
	localparam logic [7:0] OFF_EVT_MODE = 8'h0C;

	// ===========================================================
	// field positions
	localparam int SLIP_SRC_BIT = 0;
	localparam int VALID_VAL_BIT = 1;
	localparam int XFER_DIS_BIT = 3;
	localparam int VSEL_BIT = 2;
	localparam int CU_LSB = 0;
	localparam int SUM_CONV_BIT = 0;
	localparam int SUM_TX_BIT = 1;
	localparam int FLAG_XFER_BIT = 0;
	localparam int FLAG_SLIP_BIT = 1;
	localparam int FLAG_READY_BIT = 4;
	localparam int FLAG_RATIO_BIT = 5;

	// implemented bits of each register; all others read zero
	localparam logic [7:0] CTL1_VALID = 8'h03;
	localparam logic [7:0] CTL2_VALID = 8'h08;
	localparam logic [7:0] CU_SRC_VALID = 8'h07;
	localparam logic [7:0] FLAG_VALID = 8'h33;

	// ===========================================================
	// reset values
	localparam logic [7:0] RST_CTL = 8'h00;
	localparam logic [7:0] RST_MASK = 8'h00;
	localparam logic [7:0] RST_MODE = 8'h00;
	localparam logic [7:0] RST_FLAGS = 8'h00;
	localparam logic INT_N_IDLE = 1'b1;

	// ===========================================================
	// event indices and buffer layout
	localparam int EV_N = 4;
	localparam int EV_XFER = 0;
	localparam int EV_SLIP = 1;
	localparam int EV_READY = 2;
	localparam int EV_RATIO = 3;
	localparam int IDX_W = 5;
	localparam logic [4:0] CU_HOST_BYTES = 5'h0A;

	typedef enum logic [1:0] {
		TRIG_RISE = 2'b00,
		TRIG_FALL = 2'b01,
		TRIG_LEVEL = 2'b10,
		TRIG_RSVD = 2'b11
	} tcsef_trig_e;

	typedef enum logic [1:0] {
		CU_NONE = 2'b00,
		CU_HOST = 2'b01,
		CU_RX = 2'b10,
		CU_SPLIT = 2'b11
	} tcsef_cu_e;

	// spreads the four event bits onto the status register layout
	function automatic logic [7:0] tcsef_spread(input logic [3:0] ev);
		logic [7:0] v;
		v = 8'h00;
		v[FLAG_XFER_BIT] = ev[EV_XFER];
		v[FLAG_SLIP_BIT] = ev[EV_SLIP];
		v[FLAG_READY_BIT] = ev[EV_READY];
		v[FLAG_RATIO_BIT] = ev[EV_RATIO];
		return v;
	endfunction : tcsef_spread

endpackage : tcsef_pkg

/* File: hdl/tcsef_trig.sv */
// trigger detector for one event: rising edge, falling edge or level
// assumes the event source is synchronous to i_clk
`timescale 1ns/1ns

module tcsef_trig
	import tcsef_pkg::*;
(
	input wire logic i_clk, // block clock
	input wire logic i_rst_n, // synchronous reset, active low
	input wire logic i_src, // raw event condition
	input wire logic [1:0] i_mode, // trigger mode code
	output logic o_hit // event detected this cycle
);

	// ===========================================================
	// previous sample for edge detection
	logic prev_reg;

	// previous sample clears at reset, so a source already high at release counts as a rise
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			prev_reg <= 1'b0;
		end else begin
			prev_reg <= i_src;
		end
	end

	// mode decode; the reserved code never fires
	always_comb begin
		case (i_mode)
			TRIG_RISE: o_hit = i_src && !prev_reg;
			TRIG_FALL: o_hit = !i_src && prev_reg;
			TRIG_LEVEL: o_hit = i_src;
			default: o_hit = 1'b0;
		endcase
	end

	// ===========================================================
	// checks
	property p_trig_rsvd;
		@(posedge i_clk) disable iff (!i_rst_n)
		(i_mode == TRIG_RSVD) |-> !o_hit;
	endproperty
	a_trig_rsvd: assert property (p_trig_rsvd) else $error("reserved mode fired");

	property p_trig_rise;
		@(posedge i_clk) disable iff (!i_rst_n)
		(i_mode == TRIG_RISE && $past(i_mode) == TRIG_RISE) |-> (o_hit == $rose(i_src));
	endproperty
	a_trig_rise: assert property (p_trig_rise) else $error("rising edge mismatch");

endmodule : tcsef_trig

/* File: hdl/tcsef_srcsel.sv */
// c/u buffer source decode and validity bit selection
// assumes the caller supplies the index of the buffer byte being loaded
`timescale 1ns/1ns

module tcsef_srcsel
	import tcsef_pkg::*;
(
	input wire logic [1:0] i_cu_sel, // buffer source field
	input wire logic i_vsel, // validity source select
	input wire logic i_valid_val, // stored validity value
	input wire logic i_rx_v, // receiver validity bit
	input wire logic [IDX_W-1:0] i_byte_idx, // byte being loaded
	output logic o_host_en, // host may load this byte
	output logic o_rx_en, // receiver buffers load this byte
	output logic o_v_bit // transmitted validity bit
);

	// ===========================================================
	// split mode hands the low bytes to the host
	wire low_byte = (i_byte_idx < CU_HOST_BYTES);

	// zero source field blocks every update
	always_comb begin
		case (i_cu_sel)
			CU_NONE: begin
				o_host_en = 1'b0;
				o_rx_en = 1'b0;
			end
			CU_HOST: begin
				o_host_en = 1'b1;
				o_rx_en = 1'b0;
			end
			CU_RX: begin
				o_host_en = 1'b0;
				o_rx_en = 1'b1;
			end
			default: begin
				o_host_en = low_byte;
				o_rx_en = !low_byte;
			end
		endcase
	end

	// pure mux so the receiver bit passes with no added latency
	assign o_v_bit = i_vsel ? i_rx_v : i_valid_val;

endmodule : tcsef_srcsel

/* File: hdl/tcsef_top.sv */
// transmitter c/u source control, validity select and four event flags with interrupt
// assumes a byte register port: one-cycle strobes, read data the cycle after the strobe
`timescale 1ns/1ns

module tcsef_top
	import tcsef_pkg::*;
(
	input wire logic i_clk, // block clock, 25 MHz
	input wire logic i_rst_n, // synchronous reset, active low
	input wire logic [ADDR_W-1:0] i_addr, // register address
	input wire logic [DATA_W-1:0] i_wdata, // register write data
	input wire logic i_wr, // write strobe
	input wire logic i_rd, // read strobe
	output logic [DATA_W-1:0] o_rdata, // read data, cycle after i_rd
	input wire logic i_xfer_done, // user to transmit buffer transfer complete
	input wire logic i_data_slip, // asynchronous data slip seen
	input wire logic i_block_start, // transmitter block start
	input wire logic i_in_rate_done, // input rate estimator left fast mode
	input wire logic i_out_rate_done, // output rate estimator left fast mode
	input wire logic i_in_rate_higher, // input rate above output rate
	input wire logic i_rx_v_bit, // receiver validity bit
	input wire logic [IDX_W-1:0] i_user_byte_idx, // user buffer byte being loaded
	output logic o_int_n, // shared interrupt, active low
	output logic o_v_bit, // transmitted validity bit
	output logic o_user_host_en, // host loads the addressed user buffer byte
	output logic o_user_rx_en, // receiver loads the addressed user buffer byte
	output logic o_user_to_tx_en // user to transmit buffer transfers allowed
);

	// ===========================================================
	// register state
	logic [7:0] ctl1_reg;
	logic [7:0] ctl1_next;
	logic [7:0] ctl2_reg;
	logic [7:0] ctl2_next;
	logic [7:0] cu_src_reg;
	logic [7:0] cu_src_next;
	logic [7:0] mask_reg;
	logic [7:0] mask_next;
	logic [7:0] mode_reg;
	logic [7:0] mode_next;
	logic [7:0] flags_reg;
	logic [7:0] flags_next;
	logic [7:0] sum_reg;
	logic [7:0] sum_next;
	logic [7:0] rdata_reg;
	logic [7:0] rdata_next;
	logic int_n_reg;
	logic int_n_next;
	logic host_en_reg;
	logic rx_en_reg;
	logic xfer_en_reg;

	// ===========================================================
	// address decode
	wire wr_ctl1 = i_wr && (i_addr == OFF_TX_CTL1);
	wire wr_ctl2 = i_wr && (i_addr == OFF_TX_CTL2);
	wire wr_cu = i_wr && (i_addr == OFF_CU_SRC);
	wire wr_mask = i_wr && (i_addr == OFF_EVT_MASK);
	wire wr_mode = i_wr && (i_addr == OFF_EVT_MODE);
	wire rd_stat = i_rd && (i_addr == OFF_EVT_STAT);

	// unimplemented bits are dropped on write so they read back zero
	assign ctl1_next = wr_ctl1 ? (i_wdata & CTL1_VALID) : ctl1_reg;
	assign ctl2_next = wr_ctl2 ? (i_wdata & CTL2_VALID) : ctl2_reg;
	assign cu_src_next = wr_cu ? (i_wdata & CU_SRC_VALID) : cu_src_reg;
	assign mask_next = wr_mask ? (i_wdata & FLAG_VALID) : mask_reg;
	assign mode_next = wr_mode ? i_wdata : mode_reg;

	// control fields
	wire slip_src_sel = ctl1_reg[SLIP_SRC_BIT];
	wire valid_val = ctl1_reg[VALID_VAL_BIT];
	wire xfer_dis = ctl2_reg[XFER_DIS_BIT];
	wire vsel = cu_src_reg[VSEL_BIT];
	wire [1:0] cu_sel = cu_src_reg[CU_LSB+1:CU_LSB];

	// ===========================================================
	// event sources and trigger detection
	wire [EV_N-1:0] ev_src;
	wire [EV_N-1:0] ev_hit;
	wire [EV_N-1:0] ev_gate;

	assign ev_src[EV_XFER] = i_xfer_done;
	assign ev_src[EV_SLIP] = slip_src_sel ? i_block_start : i_data_slip;
	assign ev_src[EV_READY] = i_in_rate_done && i_out_rate_done;
	assign ev_src[EV_RATIO] = i_in_rate_higher;

	genvar gi;
	generate
		for (gi = 0; gi < EV_N; gi = gi + 1) begin : g_trig
			tcsef_trig u_trig (
				.i_clk(i_clk),
				.i_rst_n(i_rst_n),
				.i_src(ev_src[gi]),
				.i_mode(mode_reg[2*gi+1:2*gi]),
				.o_hit(ev_hit[gi])
			);
		end
	endgenerate

	// a completed transfer only counts while transfers are enabled
	assign ev_gate = {1'b1, 1'b1, 1'b1, !xfer_dis};

	// ===========================================================
	// sticky flags: a set in the clearing read cycle survives the clear
	wire [7:0] set_vec = tcsef_spread(ev_hit & ev_gate) & mask_reg;
	wire [7:0] clr_vec = rd_stat ? FLAG_VALID : 8'h00;

	assign flags_next = (flags_reg & ~clr_vec) | set_vec;

	// summary bits follow the flags of each side
	always_comb begin
		sum_next = 8'h00;
		sum_next[SUM_TX_BIT] = flags_next[FLAG_XFER_BIT] || flags_next[FLAG_SLIP_BIT];
		sum_next[SUM_CONV_BIT] = flags_next[FLAG_READY_BIT] || flags_next[FLAG_RATIO_BIT];
	end

	// masking a pending flag later also hides it from the pin
	assign int_n_next = ~|(flags_next & mask_next);

	// ===========================================================
	// read mux; writes to the status offset fall through and change nothing
	assign rdata_next = !i_rd ? 8'h00 :
		(i_addr == OFF_SUMMARY) ? sum_reg :
		(i_addr == OFF_TX_CTL1) ? ctl1_reg :
		(i_addr == OFF_TX_CTL2) ? ctl2_reg :
		(i_addr == OFF_CU_SRC) ? cu_src_reg :
		(i_addr == OFF_EVT_STAT) ? flags_reg :
		(i_addr == OFF_EVT_MASK) ? mask_reg :
		(i_addr == OFF_EVT_MODE) ? mode_reg : 8'h00;

	// ===========================================================
	// buffer source decode and validity selection
	wire host_en_w;
	wire rx_en_w;

	tcsef_srcsel u_srcsel (
		.i_cu_sel(cu_sel),
		.i_vsel(vsel),
		.i_valid_val(valid_val),
		.i_rx_v(i_rx_v_bit),
		.i_byte_idx(i_user_byte_idx),
		.o_host_en(host_en_w),
		.o_rx_en(rx_en_w),
		.o_v_bit(o_v_bit)
	);

	// ===========================================================
	// configuration registers
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			ctl1_reg <= RST_CTL;
			ctl2_reg <= RST_CTL;
			cu_src_reg <= RST_CTL;
			mask_reg <= RST_MASK;
			mode_reg <= RST_MODE;
		end else begin
			ctl1_reg <= ctl1_next;
			ctl2_reg <= ctl2_next;
			cu_src_reg <= cu_src_next;
			mask_reg <= mask_next;
			mode_reg <= mode_next;
		end
	end

	// flags, summary, interrupt and read data
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			flags_reg <= RST_FLAGS;
			sum_reg <= RST_FLAGS;
			int_n_reg <= INT_N_IDLE;
			rdata_reg <= 8'h00;
		end else begin
			flags_reg <= flags_next;
			sum_reg <= sum_next;
			int_n_reg <= int_n_next;
			rdata_reg <= rdata_next;
		end
	end

	// buffer enables registered so every top output except the validity bit o_v_bit is a flop
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			host_en_reg <= 1'b0;
			rx_en_reg <= 1'b0;
			xfer_en_reg <= 1'b0;
		end else begin
			host_en_reg <= host_en_w;
			rx_en_reg <= rx_en_w;
			xfer_en_reg <= !xfer_dis;
		end
	end

	assign o_rdata = rdata_reg;
	assign o_int_n = int_n_reg;
	assign o_user_host_en = host_en_reg;
	assign o_user_rx_en = rx_en_reg;
	assign o_user_to_tx_en = xfer_en_reg;

	// ===========================================================
	// checks
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);

	property p_cu_split;
		(cu_sel == CU_SPLIT && i_user_byte_idx < CU_HOST_BYTES) |=>
			(o_user_host_en && !o_user_rx_en);
	endproperty
	a_cu_split: assert property (p_cu_split) else $error("split mode low byte not host");

	property p_vbit;
		o_v_bit == (cu_src_reg[VSEL_BIT] ? i_rx_v_bit : ctl1_reg[VALID_VAL_BIT]);
	endproperty
	a_vbit: assert property (p_vbit) else $error("validity bit source wrong");

	property p_xfer_set;
		(ev_hit[EV_XFER] && mask_reg[FLAG_XFER_BIT] && !xfer_dis) |=> flags_reg[FLAG_XFER_BIT];
	endproperty
	a_xfer_set: assert property (p_xfer_set) else $error("transfer flag not set");

	property p_xfer_block;
		(!flags_reg[FLAG_XFER_BIT] && xfer_dis) |=> !flags_reg[FLAG_XFER_BIT];
	endproperty
	a_xfer_block: assert property (p_xfer_block) else $error("transfer flag set while disabled");

	property p_tx_int;
		$rose(flags_reg[FLAG_XFER_BIT]) |-> (!o_int_n && sum_reg[SUM_TX_BIT]);
	endproperty
	a_tx_int: assert property (p_tx_int) else $error("transfer flag without interrupt");

	property p_slip_src;
		(slip_src_sel && mask_reg[FLAG_SLIP_BIT] && ev_hit[EV_SLIP]
			&& mode_reg[3:2] != TRIG_FALL) |-> i_block_start;
	endproperty
	a_slip_src: assert property (p_slip_src) else $error("slip trigger not from block start");

	property p_slip_int;
		(ev_hit[EV_SLIP] && mask_reg[FLAG_SLIP_BIT] && !wr_mask) |=>
			(flags_reg[FLAG_SLIP_BIT] && !o_int_n && sum_reg[SUM_TX_BIT]);
	endproperty
	a_slip_int: assert property (p_slip_int) else $error("slip event lost");

	property p_ready;
		(ev_hit[EV_READY] && mask_reg[FLAG_READY_BIT] && !wr_mask) |=>
			(flags_reg[FLAG_READY_BIT] && !o_int_n && sum_reg[SUM_CONV_BIT]);
	endproperty
	a_ready: assert property (p_ready) else $error("rate ready event lost");

	property p_ratio;
		(ev_hit[EV_RATIO] && mask_reg[FLAG_RATIO_BIT] && !rd_stat && !wr_mask) |=>
			(flags_reg[FLAG_RATIO_BIT] && sum_reg[SUM_CONV_BIT]) ##1 flags_reg[FLAG_RATIO_BIT];
	endproperty
	a_ratio: assert property (p_ratio) else $error("ratio flag not held");

	property p_mask_gate;
		$rose(flags_reg[FLAG_RATIO_BIT]) |-> $past(mask_reg[FLAG_RATIO_BIT]);
	endproperty
	a_mask_gate: assert property (p_mask_gate) else $error("masked ratio event set flag");

	property p_stat_ro;
		(i_wr && i_addr == OFF_EVT_STAT && set_vec == 8'h00) |=> $stable(flags_reg);
	endproperty
	a_stat_ro: assert property (p_stat_ro) else $error("status write changed flags");

	property p_xfer_gate;
		xfer_dis |=> !o_user_to_tx_en;
	endproperty
	a_xfer_gate: assert property (p_xfer_gate) else $error("transfers not blocked");

	property p_rsvd_zero;
		(i_rd && i_addr == OFF_EVT_MASK) |=> (o_rdata[7:6] == 2'b00 && o_rdata[3:2] == 2'b00);
	endproperty
	a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved mask bits nonzero");

	property p_rd_clear;
		(rd_stat && set_vec == 8'h00) |=> (flags_reg == 8'h00 && o_int_n
			&& o_rdata == $past(flags_reg));
	endproperty
	a_rd_clear: assert property (p_rd_clear) else $error("status read did not clear");

endmodule : tcsef_top

/* File: verif/tcsef_host.sv */
// host model: drives the byte register port of the event flag block
// assumes one clock; strobes change by non-blocking assignment after a rising edge
`timescale 1ns/1ns

module tcsef_host
	import tcsef_pkg::*;
(
	input wire logic i_clk, // block clock
	output logic [ADDR_W-1:0] o_addr, // register address
	output logic [DATA_W-1:0] o_wdata, // write data
	output logic o_wr, // write strobe
	output logic o_rd, // read strobe
	input wire logic [DATA_W-1:0] i_rdata // read data
);

	// ==========================================================
	// idle bus at time zero
	initial begin
		o_addr = 8'h00;
		o_wdata = 8'h00;
		o_wr = 1'b0;
		o_rd = 1'b0;
	end

	// ==========================================================
	// one-cycle write; the slave never stalls
	task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_clk);
		o_addr <= a;
		o_wdata <= d;
		o_wr <= 1'b1;
		@(posedge i_clk);
		o_wr <= 1'b0;
		o_wdata <= ~d; // stale data is scrambled so a late sample shows
	endtask : write_reg

	// read data stand only in the cycle after the strobe
	task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
		@(posedge i_clk);
		o_addr <= a;
		o_rd <= 1'b1;
		@(posedge i_clk);
		o_rd <= 1'b0;
		#1;
		d = i_rdata;
	endtask : read_reg

endmodule : tcsef_host

/* File: verif/tcsef_top_tb.sv */
// self-checking bench of the transmitter c/u source and event flag block
// assumes the host model for register traffic and bench-driven event sources
`timescale 1ns/1ns

module tcsef_top_tb;
	import tcsef_pkg::*;

	logic i_clk = 1'b0;
	logic i_rst_n = 1'b0;
	logic [7:0] addr, wdata, o_rdata;
	logic wr, rd, o_int_n, o_v_bit, host_en, rx_en, xfer_en;
	logic [3:0] ev_src = 4'h0;
	logic out_done = 1'b1;
	logic blk = 1'b0;
	logic rx_v = 1'b0;
	logic [4:0] idx = 5'h00;
	int fail_count = 0;
	int samples_checked = 0;
	logic [7:0] ev_bit [4] = '{8'h01, 8'h02, 8'h10, 8'h20};

	// ==========================================================
	// 25 MHz clock
	always #20 i_clk = ~i_clk;

	tcsef_host host (.i_clk(i_clk), .o_addr(addr), .o_wdata(wdata), .o_wr(wr),
		.o_rd(rd), .i_rdata(o_rdata));

	tcsef_top dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(addr), .i_wdata(wdata),
		.i_wr(wr), .i_rd(rd), .o_rdata(o_rdata), .i_xfer_done(ev_src[0]),
		.i_data_slip(ev_src[1]), .i_block_start(blk), .i_in_rate_done(ev_src[2]),
		.i_out_rate_done(out_done), .i_in_rate_higher(ev_src[3]), .i_rx_v_bit(rx_v),
		.i_user_byte_idx(idx), .o_int_n(o_int_n), .o_v_bit(o_v_bit),
		.o_user_host_en(host_en), .o_user_rx_en(rx_en), .o_user_to_tx_en(xfer_en));

	// ==========================================================
	// comparison and verdict
	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
		samples_checked++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : chk

	task automatic print_verdict();
		if (fail_count == 0 && samples_checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : print_verdict

	// ==========================================================
	// scenarios
	// reset values, reserved bits, read-only and unmapped places
	task automatic reg_case();
		logic [7:0] d;
		logic [7:0] adr [8] = '{8'h09, 8'h0A, 8'h0B, 8'h0C, 8'h07, 8'h08, 8'h02, 8'h55};
		logic [7:0] msk [8] = '{8'h07, 8'h00, 8'h33, 8'hFF, 8'h03, 8'h08, 8'h00, 8'h00};
		for (int i = 0; i < 8; i++) begin
			host.read_reg(adr[i], d);
			chk(d, 8'h00, "reset value");
			host.write_reg(adr[i], 8'hFF);
			host.read_reg(adr[i], d);
			chk(d, msk[i], "writable bits");
			host.write_reg(adr[i], 8'h00);
		end
	endtask : reg_case

	// one source pulse under a given mask and trigger mode
	task automatic ev_case(input int e, input logic [1:0] md, input logic mk, input logic hit);
		logic [7:0] d;
		host.write_reg(OFF_EVT_MASK, mk ? ev_bit[e] : 8'h00);
		host.write_reg(OFF_EVT_MODE, {6'h00, md} << (2 * e));
		host.read_reg(OFF_EVT_STAT, d);
		@(posedge i_clk);
		ev_src[e] <= 1'b1;
		repeat (3) @(posedge i_clk);
		ev_src[e] <= 1'b0;
		repeat (3) @(posedge i_clk);
		#1;
		chk({7'h00, o_int_n}, {7'h00, !hit}, "interrupt line");
		host.read_reg(OFF_SUMMARY, d);
		chk(d, hit ? (e < 2 ? 8'h02 : 8'h01) : 8'h00, "summary");
		host.read_reg(OFF_EVT_STAT, d);
		chk(d, hit ? ev_bit[e] : 8'h00, "flags");
		host.read_reg(OFF_EVT_STAT, d);
		chk(d, 8'h00, "flags after read");
		chk({7'h00, o_int_n}, 8'h01, "interrupt released");
	endtask : ev_case

	// block start chosen as slip trigger; data slip then ignored
	task automatic blk_case();
		logic [7:0] d;
		host.write_reg(OFF_TX_CTL1, 8'h01);
		ev_case(1, 2'b00, 1'b1, 1'b0);
		@(posedge i_clk);
		blk <= 1'b1;
		repeat (2) @(posedge i_clk);
		blk <= 1'b0;
		host.read_reg(OFF_EVT_STAT, d);
		chk(d, 8'h02, "block start flag");
		host.write_reg(OFF_TX_CTL1, 8'h00);
	endtask : blk_case

	// transfer disable gates transfers and the done flag
	task automatic dis_case();
		host.write_reg(OFF_TX_CTL2, 8'h08);
		repeat (2) @(posedge i_clk);
		#1;
		chk({7'h00, xfer_en}, 8'h00, "transfer gate");
		ev_case(0, 2'b00, 1'b1, 1'b0);
		host.write_reg(OFF_TX_CTL2, 8'h00);
		repeat (2) @(posedge i_clk);
		#1;
		chk({7'h00, xfer_en}, 8'h01, "transfer gate");
	endtask : dis_case

	// every source code at the split boundary, bytes 9 and 10
	task automatic cu_case();
		logic [1:0] c;
		logic h, r;
		for (int k = 0; k < 4; k++) begin
			c = k[1:0];
			host.write_reg(OFF_CU_SRC, {6'h00, c});
			for (int j = 9; j < 11; j++) begin
				h = (c == 2'b01) || (c == 2'b11 && j < 10);
				r = (c == 2'b10) || (c == 2'b11 && j >= 10);
				@(posedge i_clk);
				idx <= 5'(j);
				repeat (2) @(posedge i_clk);
				#1;
				chk({6'h00, host_en, rx_en}, {6'h00, h, r}, "buffer source");
			end
		end
	endtask : cu_case

	// validity bit: stored value or receiver bit with no delay
	task automatic vbit_case();
		host.write_reg(OFF_TX_CTL1, 8'h02);
		for (int k = 0; k < 4; k++) begin
			host.write_reg(OFF_CU_SRC, {5'h00, k[1], 2'b00});
			@(posedge i_clk);
			rx_v <= k[0];
			#1;
			chk({7'h00, o_v_bit}, {7'h00, k[1] ? k[0] : 1'b1}, "validity bit");
		end
		host.write_reg(OFF_TX_CTL1, 8'h00);
	endtask : vbit_case

	// ==========================================================
	// watchdog: a hang ends the run as a mismatch
	initial begin
		repeat (20000) @(posedge i_clk);
		fail_count++;
		print_verdict();
	end

	// main sequence
	initial begin
		repeat (12) @(posedge i_clk);
		i_rst_n <= 1'b1;
		#1;
		chk({7'h00, o_int_n}, 8'h01, "interrupt idle");
		reg_case();
		for (int m = 0; m < 4; m++) begin
			ev_case(3, m[1:0], 1'b1, m != 3);
		end
		ev_case(0, 2'b00, 1'b1, 1'b1);
		ev_case(1, 2'b01, 1'b1, 1'b1);
		ev_case(2, 2'b10, 1'b1, 1'b1);
		ev_case(1, 2'b00, 1'b0, 1'b0);
		@(posedge i_clk);
		out_done <= 1'b0;
		ev_case(2, 2'b00, 1'b1, 1'b0);
		@(posedge i_clk);
		out_done <= 1'b1;
		blk_case();
		dis_case();
		cu_case();
		vbit_case();
		print_verdict();
	end

endmodule : tcsef_top_tb
